// ===== logic/lppc_pkg.sv
// Constants, register map and carrier types of the low power pulse counter.
// Assumes a 125 MHz system clock and an RTC clock level sampled on it.
// Contract
// - Two 24-bit counters, wrap past 16,777,215
// - Counter overflow raises a wake-up event
// - Two 24-bit thresholds wake on counter match
// - Sampling, debounce, pull-ups timed by RTC clock
// - Counts in sleep without processor help
// - Single mode: input zero, counter zero only
// - Dual mode: own counters, shared settings
// - Quadrature: clockwise counter zero, else one
// - Pull-up enable high connects the resistor
// - Sample only after pull-up charging completes
// - Integrator starts at 4, low at 0
// - Integrator climbs back to 4 for high
// - Processor reset leaves counters and registers alone
// - Counters kept until mode register write
// - Mode write selects mode, resets other registers; code keeps global enable and wake register
// - No counting for two RTC cycles after reset
// - Interrupt needs source enable and global enable
// - Wake flag set when counter caused wake-up
package lppc_pkg;
    localparam int CNT_W = 24;
    localparam logic [23:0] CNT_MAX = 24'hFFFFFF;
    // Register byte offsets
    localparam logic [5:0] OFS_MODE = 6'h00;
    localparam logic [5:0] OFS_CNT0 = 6'h04;
    localparam logic [5:0] OFS_CNT1 = 6'h08;
    localparam logic [5:0] OFS_CMP0 = 6'h0C;
    localparam logic [5:0] OFS_CMP1 = 6'h10;
    localparam logic [5:0] OFS_IEN = 6'h14;
    localparam logic [5:0] OFS_IFLAG = 6'h18;
    localparam logic [5:0] OFS_GCTRL = 6'h1C;
    localparam logic [5:0] OFS_WAKE = 6'h20;
    // Field positions
    localparam int MODE_POL_BIT = 5;
    localparam int GLOB_EN_BIT = 4;
    localparam int WAKE_FLAG_BIT = 0;
    localparam int WAKE_EN_BIT = 1;
    // Sync count in RTC cycles, integrator counts in samples
    localparam logic [1:0] SYNC_TICKS = 2'h2;
    localparam logic [2:0] INTEG_TOP = 3'h4;
    localparam logic [2:0] INTEG_RST = 3'h4;
    localparam logic [31:0] RD_ZERO = 32'h00000000;

    typedef enum logic [1:0] {
        LPPC_OFF, LPPC_SINGLE, LPPC_DUAL, LPPC_QUAD
    } lppc_mode_t;

    // Master mode register contents
    typedef struct packed {
        logic pol;
        logic [2:0] rate;
        lppc_mode_t mode;
    } lppc_cfg_t;

    // One bit per interrupt and wake source
    typedef struct packed {
        logic cmp1;
        logic cmp0;
        logic ovf1;
        logic ovf0;
    } lppc_evt_t;
endpackage : lppc_pkg

// ===== logic/lppc_debounce.sv
// Symmetric digital integrator filtering one sampled input.
// Assumes smp_en pulses once per completed pull-up sample.
`timescale 1ns/1ps
module lppc_debounce
    import lppc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control
    input wire logic clr,
    input wire logic smp_en,
    input wire logic din,
    // Filtered level
    output logic dout
);
    logic [2:0] integ_q;

    // Integrator; output only flips at the rails
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            integ_q <= INTEG_RST;
            dout <= 1'b1;
        end else if (clr) begin
            integ_q <= INTEG_RST;
            dout <= 1'b1;
        end else if (smp_en) begin
            if (!din && integ_q != 3'h0) begin
                integ_q <= integ_q - 3'h1;
                if (integ_q == 3'h1) begin
                    dout <= 1'b0;
                end
            end else if (din && integ_q != INTEG_TOP) begin
                integ_q <= integ_q + 3'h1;
                if (integ_q == INTEG_TOP - 3'h1) begin
                    dout <= 1'b1;
                end
            end
        end
    end

    AST_DB_FALL: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(dout) |-> $past(integ_q) == 3'h1 && integ_q == 3'h0)
        else $error("debounce fell away from zero");
    AST_DB_RISE: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(dout) && !$past(clr) |-> integ_q == INTEG_TOP)
        else $error("debounce rose below top");
endmodule : lppc_debounce

// ===== logic/lppc_quad.sv
// Quadrature step decoder for two debounced channels.
// Assumes both inputs already filtered; one step per cycle of channel a.
`timescale 1ns/1ps
module lppc_quad
    import lppc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control
    input wire logic clr,
    input wire logic a,
    input wire logic b,
    // Step pulses
    output logic cw,
    output logic ccw
);
    logic a_q;

    // Step on rising a; phase of b gives direction
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            a_q <= 1'b1;
            cw <= 1'b0;
            ccw <= 1'b0;
        end else begin
            a_q <= clr ? 1'b1 : a;
            cw <= !clr && a && !a_q && !b;
            ccw <= !clr && a && !a_q && b;
        end
    end

    AST_QUAD_EXCL: assert property (@(posedge clk) disable iff (!rst_n)
        !(cw && ccw))
        else $error("both directions stepped");
endmodule : lppc_quad

// ===== logic/lppc_top.sv
// Low power pulse counter: RTC-timed sampling with pull-up pulses,
// debounce, three counting modes, two counters with thresholds, flags.
// Assumes a classic Wishbone master and an RTC clock level input.
`timescale 1ns/1ps
module lppc_top
    import lppc_pkg::*;
(
    // Clock and reset of the backup domain
    input wire logic clk,
    input wire logic rst_n,
    // Processor reset, kept away from counter state
    input wire logic cpu_rst_n,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [5:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // RTC clock level and pulse inputs
    input wire logic rtc_clk_i,
    input wire logic pulse_input_zero,
    input wire logic pulse_input_one,
    // Processor power state
    input wire logic sleep_i,
    // Pull-up enables, events
    output logic [1:0] pullup_en_o,
    output logic irq_o,
    output logic wake_o
);
    ////////////////////////////////////////////////////////////////////////
    // Byte lane merge for writable words
    function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
            input logic [31:0] new_v, input logic [3:0] sel);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction : lane_merge

    typedef enum logic {SMP_IDLE, SMP_CHARGE} lppc_smp_t;

    lppc_cfg_t cfg_q;
    lppc_smp_t smp_q;
    logic [23:0] cnt0_q, cnt1_q, cmp0_q, cmp1_q;
    logic [3:0] ien_q;
    lppc_evt_t flag_q, evt;
    logic glob_en_q, wake_en_q, wake_flag_q;
    logic [1:0] sync_q;
    logic [7:0] div_q;
    logic rtc_q, tick, smp_pulse;
    logic [1:0] raw_q;
    logic db0, db1, db0_q, db1_q, cw, ccw;
    logic inc0, inc1, edge0, edge1;
    logic bus_req, wr_fire, mode_wr;
    logic [31:0] rd_d;
    logic [31:0] cmp0_m, cmp1_m;
    logic [7:0] period;

    ////////////////////////////////////////////////////////////////////////
    // Wishbone decode; one cycle to ack, then ack drops
    // Processor reset refuses the request outright, so nothing lands unacked
    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o && cpu_rst_n;
    assign wr_fire = bus_req && wb_we_i;
    assign mode_wr = wr_fire && wb_adr_i == OFS_MODE && wb_sel_i[0];
    // Byte lane merge of the threshold words
    assign cmp0_m = lane_merge({8'h00, cmp0_q}, wb_dat_i, wb_sel_i);
    assign cmp1_m = lane_merge({8'h00, cmp1_q}, wb_dat_i, wb_sel_i);

    // Ack follows the gated request; its register resets only with rst_n
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= bus_req;
        end
    end

    // Read mux; unmapped offsets read zero
    always_comb begin
        rd_d = RD_ZERO;
        unique case (wb_adr_i)
            OFS_MODE: rd_d[5:0] = cfg_q;
            OFS_CNT0: rd_d[23:0] = cnt0_q;
            OFS_CNT1: rd_d[23:0] = cnt1_q;
            OFS_CMP0: rd_d[23:0] = cmp0_q;
            OFS_CMP1: rd_d[23:0] = cmp1_q;
            OFS_IEN: rd_d[3:0] = ien_q;
            OFS_IFLAG: rd_d[3:0] = flag_q;
            OFS_GCTRL: rd_d[GLOB_EN_BIT] = glob_en_q;
            OFS_WAKE: rd_d[1:0] = {wake_en_q, wake_flag_q};
            default: rd_d = RD_ZERO;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wb_dat_o <= RD_ZERO;
        end else if (bus_req && !wb_we_i) begin
            wb_dat_o <= rd_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Mode register; a write restarts the block except global enable and wake register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_q <= '0;
        end else if (mode_wr) begin
            cfg_q <= lppc_cfg_t'(wb_dat_i[5:0]);
        end
    end

    // Thresholds and enables, cleared by a mode write
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cmp0_q <= '0;
            cmp1_q <= '0;
            ien_q <= '0;
        end else if (mode_wr) begin
            cmp0_q <= '0;
            cmp1_q <= '0;
            ien_q <= '0;
        end else if (wr_fire) begin
            if (wb_adr_i == OFS_CMP0) begin
                cmp0_q <= cmp0_m[23:0];
            end
            if (wb_adr_i == OFS_CMP1) begin
                cmp1_q <= cmp1_m[23:0];
            end
            if (wb_adr_i == OFS_IEN && wb_sel_i[0]) begin
                ien_q <= wb_dat_i[3:0];
            end
        end
    end

    // Global enable sits outside the block's reset group
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            glob_en_q <= 1'b0;
        end else if (wr_fire && wb_adr_i == OFS_GCTRL && wb_sel_i[0]) begin
            glob_en_q <= wb_dat_i[GLOB_EN_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // RTC edge gives the sampling time base
    assign tick = rtc_clk_i && !rtc_q;
    assign period = 8'(8'h01 << cfg_q.rate);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rtc_q <= 1'b0;
        end else begin
            rtc_q <= rtc_clk_i;
        end
    end

    // Sync window after a block reset; counting held off
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_q <= SYNC_TICKS;
        end else if (mode_wr) begin
            sync_q <= SYNC_TICKS;
        end else if (tick && sync_q != 2'h0) begin
            sync_q <= sync_q - 2'h1;
        end
    end

    // Pull-up pulse per period; sample when charging ends
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            smp_q <= SMP_IDLE;
            div_q <= '0;
            pullup_en_o <= 2'b00;
            smp_pulse <= 1'b0;
            raw_q <= 2'b11;
        end else begin
            smp_pulse <= 1'b0;
            if (mode_wr || cfg_q.mode == LPPC_OFF) begin
                smp_q <= SMP_IDLE;
                div_q <= '0;
                pullup_en_o <= 2'b00;
            end else if (tick) begin
                unique case (smp_q)
                    SMP_IDLE: begin
                        if (div_q >= period - 8'h01) begin
                            div_q <= '0;
                            smp_q <= SMP_CHARGE;
                            pullup_en_o <= {cfg_q.mode != LPPC_SINGLE,
                                1'b1};
                        end else begin
                            div_q <= div_q + 8'h01;
                        end
                    end
                    SMP_CHARGE: begin
                        raw_q <= {pulse_input_one, pulse_input_zero};
                        smp_pulse <= 1'b1;
                        pullup_en_o <= 2'b00;
                        smp_q <= SMP_IDLE;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Shared filter settings on both channels
    lppc_debounce u_db0 (
        .clk(clk),
        .rst_n(rst_n),
        .clr(mode_wr),
        .smp_en(smp_pulse),
        .din(raw_q[0]),
        .dout(db0)
    );

    lppc_debounce u_db1 (
        .clk(clk),
        .rst_n(rst_n),
        .clr(mode_wr),
        .smp_en(smp_pulse),
        .din(raw_q[1]),
        .dout(db1)
    );

    lppc_quad u_quad (
        .clk(clk),
        .rst_n(rst_n),
        .clr(mode_wr),
        .a(db0),
        .b(db1),
        .cw(cw),
        .ccw(ccw)
    );

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            db0_q <= 1'b1;
            db1_q <= 1'b1;
        end else begin
            db0_q <= db0;
            db1_q <= db1;
        end
    end

    // Selected polarity: pol low counts closures (falling)
    assign edge0 = cfg_q.pol ? (db0 && !db0_q) : (!db0 && db0_q);
    assign edge1 = cfg_q.pol ? (db1 && !db1_q) : (!db1 && db1_q);

    // Mode steering, gated by the sync window
    always_comb begin
        inc0 = 1'b0;
        inc1 = 1'b0;
        if (sync_q == 2'h0 && !mode_wr) begin
            unique case (cfg_q.mode)
                LPPC_OFF: inc0 = 1'b0;
                LPPC_SINGLE: inc0 = edge0;
                LPPC_DUAL: begin
                    inc0 = edge0;
                    inc1 = edge1;
                end
                LPPC_QUAD: begin
                    inc0 = cw;
                    inc1 = ccw;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Counters survive processor reset; cleared only by rst_n or a mode write
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt0_q <= '0;
            cnt1_q <= '0;
        end else if (mode_wr) begin
            cnt0_q <= '0;
            cnt1_q <= '0;
        end else begin
            cnt0_q <= cnt0_q + 24'(inc0);
            cnt1_q <= cnt1_q + 24'(inc1);
        end
    end

    // Events: wrap and threshold hit
    assign evt.ovf0 = inc0 && cnt0_q == CNT_MAX;
    assign evt.ovf1 = inc1 && cnt1_q == CNT_MAX;
    assign evt.cmp0 = inc0 && cnt0_q + 24'h000001 == cmp0_q;
    assign evt.cmp1 = inc1 && cnt1_q + 24'h000001 == cmp1_q;

    // Sticky flags, write one to clear, a new event beats the clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flag_q <= '0;
        end else if (mode_wr) begin
            flag_q <= '0;
        end else if (wr_fire && wb_adr_i == OFS_IFLAG && wb_sel_i[0]) begin
            flag_q <= (flag_q & ~wb_dat_i[3:0]) | evt;
        end else begin
            flag_q <= flag_q | evt;
        end
    end

    // Interrupt needs source and global enable
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= glob_en_q && |(flag_q & ien_q);
        end
    end

    // Wake request while asleep; flag records the cause
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wake_o <= 1'b0;
            wake_en_q <= 1'b0;
            wake_flag_q <= 1'b0;
        end else begin
            wake_o <= sleep_i && wake_en_q && |(evt & ien_q);
            if (wr_fire && wb_adr_i == OFS_WAKE && wb_sel_i[0]) begin
                wake_en_q <= wb_dat_i[WAKE_EN_BIT];
            end
            if (wake_o) begin
                wake_flag_q <= 1'b1;
            end else if (wr_fire && wb_adr_i == OFS_WAKE && wb_sel_i[0]
                    && wb_dat_i[WAKE_FLAG_BIT]) begin
                wake_flag_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    AST_PU_CHARGE: assert property (pullup_en_o[0] |-> smp_q == SMP_CHARGE)
        else $error("pull-up on outside charge");
    AST_SMP_AFTER: assert property (smp_pulse |-> $past(pullup_en_o[0]))
        else $error("sample taken without charge");
    AST_SYNC_HOLD: assert property (sync_q != 2'h0 |-> !inc0 && !inc1)
        else $error("count during sync window");
    AST_MODE_CLR: assert property (mode_wr |=> cnt0_q == '0 && cnt1_q == '0
        && flag_q == '0 && sync_q == SYNC_TICKS)
        else $error("mode write did not restart");
    AST_SINGLE: assert property (cfg_q.mode == LPPC_SINGLE |-> !inc1)
        else $error("counter one moved in single mode");
    AST_WRAP: assert property (inc0 && cnt0_q == CNT_MAX && !mode_wr
        |=> cnt0_q == '0 && flag_q.ovf0)
        else $error("overflow wrap or flag missing");
    AST_CMP: assert property (evt.cmp0 && !mode_wr |=> flag_q.cmp0)
        else $error("threshold flag missing");
    AST_IRQ: assert property (irq_o |-> $past(glob_en_q))
        else $error("interrupt without global enable");
    AST_HOLD: assert property (!inc0 && !mode_wr |=> $stable(cnt0_q))
        else $error("counter moved without step");
    COV_QUAD: cover property (cfg_q.mode == LPPC_QUAD && inc1);
    COV_DUAL: cover property (cfg_q.mode == LPPC_DUAL && inc0 && inc1);
    COV_WAKE: cover property (wake_o ##1 wake_flag_q);
endmodule : lppc_top

// ===== tb/lppc_meter_model.sv
// Two-channel reed switch model driving the meter lines.
// Assumes the bench sets switch states; lines need the pull-up to read high.
`timescale 1ns/1ps
module lppc_meter_model (
    // Clock
    input wire logic clk,
    // Pull-up enables and switch states
    input wire logic [1:0] pullup_en,
    input wire logic [1:0] closed,
    // Meter lines
    output logic [1:0] line
);
    logic [1:0] hold_q [2] = '{2'h0, 2'h0};

    ////////////////////////////////////////////////////////////////////////
    // Residual charge lasts two clocks, then the open line sags to ground
    always_ff @(posedge clk) begin
        for (int i = 0; i < 2; i++) begin
            if (pullup_en[i]) begin
                hold_q[i] <= 2'h2;
            end else if (hold_q[i] != 2'h0) begin
                hold_q[i] <= hold_q[i] - 2'h1;
            end
        end
    end

    // Closed switch shorts the line; open reads high only while charged
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            line[i] = !closed[i] && (pullup_en[i] || hold_q[i] != 2'h0);
        end
    end
endmodule : lppc_meter_model

// ===== tb/test_lppc_top.sv
// Self-checking bench for the low power pulse counter.
// Assumes lppc_top with a classic Wishbone slave and the meter model.
`timescale 1ns/1ps
module test_lppc_top import lppc_pkg::*;;
    logic clk, rst_n, cpu_rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [5:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, q;
    logic rtc_clk_i, rtc_run, sleep_i, irq_o, wake_o;
    logic [1:0] pullup_en_o, line, closed, div;
    int failures, check_count, wake_seen, n, m;
    integer seed = 32'h43538C5C;

    lppc_top dut (.clk(clk), .rst_n(rst_n), .cpu_rst_n(cpu_rst_n),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rtc_clk_i(rtc_clk_i),
        .pulse_input_zero(line[0]), .pulse_input_one(line[1]),
        .sleep_i(sleep_i), .pullup_en_o(pullup_en_o), .irq_o(irq_o),
        .wake_o(wake_o));
    lppc_meter_model meter (.clk(clk), .pullup_en(pullup_en_o),
        .closed(closed), .line(line));

    ////////////////////////////////////////////////////////////////////////
    // Clock, slow RTC level kept running while counting, wake counter
    always #4 clk = ~clk;
    always @(posedge clk) begin
        div <= div + 2'h1;
        if (rtc_run) rtc_clk_i <= div[1];
        if (wake_o === 1'b1) wake_seen <= wake_seen + 1;
    end

    task automatic give_verdict;
        if (failures == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [31:0] act, input logic [31:0] exp,
                       input string what);
        check_count++;
        if (act !== exp) begin
            failures++;
            $display("unexpected at %0t: %s got %h", $time, what, act);
        end
    endtask : chk

    // One classic cycle; held until ack is sampled high
    task automatic wb(input logic we, input logic [5:0] a,
                      input logic [31:0] d, input logic [3:0] s,
                      output logic [31:0] rq);
        int k;
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= s;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 100);
        rq = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        if (k >= 100) begin
            failures++;
            $display("unexpected at %0t: bus timeout", $time);
            give_verdict();
        end
    endtask : wb

    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] rq;
        wb(1'b1, a, d, 4'hF, rq);
    endtask : wr

    task automatic rd(input logic [5:0] a, input logic [31:0] exp,
                      input string what);
        logic [31:0] rq;
        wb(1'b0, a, 32'h0, 4'hF, rq);
        chk(rq, exp, what);
    endtask : rd

    // Random hold keeps each level well past four debounce samples
    task automatic pulses(input logic [1:0] ch, input int cnt);
        repeat (cnt) begin
            closed <= closed | ch;
            repeat (90 + $unsigned($random(seed)) % 40) @(posedge clk);
            closed <= closed & ~ch;
            repeat (90 + $unsigned($random(seed)) % 40) @(posedge clk);
        end
    endtask : pulses

    function automatic logic [31:0] mode_word(input logic [1:0] md,
                                              input logic pol,
                                              input logic [2:0] rate);
        mode_word = {26'h0, pol, rate, md};
    endfunction : mode_word

    // Counters wrap at 24 bits
    function automatic logic [31:0] cnt_exp(input int c);
        cnt_exp = {8'h0, 24'(c)};
    endfunction : cnt_exp

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 0; rst_n = 0; cpu_rst_n = 1; wb_cyc_i = 0; wb_stb_i = 0;
        wb_we_i = 0; wb_adr_i = 0; wb_sel_i = 0; wb_dat_i = 0; div = 0;
        rtc_clk_i = 0; rtc_run = 1; closed = 0; sleep_i = 0;
        failures = 0; check_count = 0; wake_seen = 0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        rd(OFS_CNT0, 32'h0, "cnt0 after reset");
        rd(6'h3C, 32'h0, "unmapped read");
        // Single mode: switch one toggles too but must not count
        wr(OFS_MODE, mode_word(LPPC_SINGLE, 1'b0, 3'h0));
        m = 0;
        while (pullup_en_o[0] !== 1'b1 && m < 200) begin
            @(posedge clk);
            m++;
        end
        chk({31'h0, pullup_en_o[0]}, 32'h1, "pull-up pulse");
        n = 2 + $unsigned($random(seed)) % 4;
        pulses(2'b11, n);
        rd(OFS_CNT0, cnt_exp(n), "single cnt0");
        rd(OFS_CNT1, 32'h0, "single cnt1");
        // Short closure is bounce, not a count
        closed <= 2'b01;
        repeat (3) @(posedge clk);
        closed <= 2'b00;
        repeat (120) @(posedge clk);
        rd(OFS_CNT0, cnt_exp(n), "glitch");
        // Processor reset stops the RTC; counts survive it
        cpu_rst_n <= 1'b0;
        rtc_run <= 1'b0;
        repeat (50) @(posedge clk);
        cpu_rst_n <= 1'b1;
        rtc_run <= 1'b1;
        rd(OFS_CNT0, cnt_exp(n), "cnt0 after cpu reset");
        sleep_i <= 1'b1;
        pulses(2'b01, 1);
        sleep_i <= 1'b0;
        rd(OFS_CNT0, cnt_exp(n + 1), "count in sleep");
        // Dual mode, rising polarity, slower rate
        wr(OFS_MODE, mode_word(LPPC_DUAL, 1'b1, 3'h1));
        rd(OFS_CNT0, 32'h0, "cleared by mode write");
        m = 1 + $unsigned($random(seed)) % 3;
        pulses(2'b01, n);
        pulses(2'b10, m);
        rd(OFS_CNT0, cnt_exp(n), "dual cnt0");
        rd(OFS_CNT1, cnt_exp(m), "dual cnt1");
        // Quadrature: channel one low steers to counter zero
        wr(OFS_MODE, mode_word(LPPC_QUAD, 1'b0, 3'h0));
        closed <= 2'b10;
        repeat (100) @(posedge clk);
        pulses(2'b01, 2);
        closed <= 2'b00;
        repeat (100) @(posedge clk);
        pulses(2'b01, 1);
        rd(OFS_CNT0, cnt_exp(2), "quad cw");
        rd(OFS_CNT1, cnt_exp(1), "quad ccw");
        // Threshold with global enable off, then on; wake while asleep
        wr(OFS_MODE, mode_word(LPPC_SINGLE, 1'b0, 3'h0));
        wb(1'b1, OFS_CMP1, 32'h00ABCDEF, 4'h1, q);
        rd(OFS_CMP1, 32'h000000EF, "byte lane write");
        wr(OFS_CMP0, 32'h2);
        wr(OFS_IEN, 32'h4);
        wr(OFS_WAKE, 32'h2);
        sleep_i <= 1'b1;
        pulses(2'b01, 2);
        sleep_i <= 1'b0;
        rd(OFS_IFLAG, 32'h4, "threshold flag");
        chk({31'h0, irq_o}, 32'h0, "irq gated");
        chk(32'(wake_seen), 32'h1, "wake pulses");
        rd(OFS_WAKE, 32'h3, "wake flag");
        wr(OFS_GCTRL, 32'h10);
        repeat (2) @(posedge clk);
        chk({31'h0, irq_o}, 32'h1, "irq enabled");
        rd(OFS_IFLAG, 32'h4, "handler read");
        wr(OFS_IFLAG, 32'h4);
        repeat (2) @(posedge clk);
        chk({31'h0, irq_o}, 32'h0, "irq cleared");
        rd(OFS_IFLAG, 32'h0, "flag cleared");
        give_verdict();
    end
endmodule : test_lppc_top
